// ==== include/chan_pkg.sv ====
package chan_pkg;

  // Register offsets on the parallel register port
  localparam logic [7:0] OFS_CMD  = 8'h01;
  localparam logic [7:0] OFS_SRE  = 8'h02;
  localparam logic [7:0] OFS_CHAN = 8'h64;

  // Service request enable field positions
  localparam int unsigned SRE_DSR  = 7;
  localparam int unsigned SRE_CD   = 6;
  localparam int unsigned SRE_CTS  = 5;
  localparam int unsigned SRE_RXD  = 4;
  localparam int unsigned SRE_SPEC = 3;
  localparam int unsigned SRE_TXR  = 2;
  localparam int unsigned SRE_TXE  = 1;
  localparam int unsigned SRE_IDLE_TO = 0;

  // Channel command field positions
  localparam int unsigned CMD_RESET_BIT = 7;
  localparam int unsigned CMD_OPT_BIT   = 6;
  localparam int unsigned CMD_SEND_BIT  = 5;
  localparam int unsigned CMD_CTL_BIT   = 4;
  localparam int unsigned RESET_TYPE_BIT = 0;

  // Values after reset
  localparam logic [7:0] SRE_RESET = 8'h00;
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [7:0] CMD_IDLE  = 8'h00;

  // Receive idle time-out, time and derived cycle count
  localparam int unsigned CLK_PERIOD_NS     = 8;
  localparam int unsigned RX_IDLE_TIMEOUT_NS = 1000;
  localparam int unsigned RX_IDLE_CYCLES =
    (RX_IDLE_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Decoded command kind
  typedef enum logic [2:0] {
    CMD_NONE    = 3'b000,
    CMD_RST     = 3'b001,
    CMD_OPTION  = 3'b010,
    CMD_SEND    = 3'b011,
    CMD_CONTROL = 3'b100
  } cmd_kind_e;

  // Host user-side operation codes
  typedef enum logic [1:0] {
    OP_WRITE = 2'b00,
    OP_READ  = 2'b01,
    OP_CMD   = 2'b10
  } host_op_e;

endpackage : chan_pkg

// ==== include/chan_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface chan_if #(parameter int unsigned NCH = 8);
  logic [7:0]     addr;
  logic [7:0]     wdata;
  logic           wr;
  logic           rd;
  logic [7:0]     rdata;
  logic           rvalid;
  logic [NCH-1:0] modem_req;
  logic [NCH-1:0] rx_req;
  logic [NCH-1:0] rx_exc_req;
  logic [NCH-1:0] tx_req;
  logic [NCH-1:0] txe_req;
  logic [NCH-1:0] ack_modem;
  logic [NCH-1:0] ack_rx;
  logic [NCH-1:0] ack_exc;

  modport dev (input addr, wdata, wr, rd, ack_modem, ack_rx, ack_exc,
               output rdata, rvalid, modem_req, rx_req, rx_exc_req, tx_req, txe_req);
  modport host (output addr, wdata, wr, rd, ack_modem, ack_rx, ack_exc,
                input rdata, rvalid, modem_req, rx_req, rx_exc_req, tx_req, txe_req);
endinterface : chan_if
`default_nettype wire

// ==== verilog/chan_dev.sv ====
// Summary of operation
// - Each enable bit gates its own request cause
// - Bit 7 enables data-set-ready change requests
// - Bit 6 enables carrier-detect change requests
// - Bit 5 enables clear-to-send change requests
// - Bit 4 enables receive data and error exceptions
// - Bit 3 enables special-character match exceptions
// - Without bit 3, exceptions only errors, time-outs
// - Transparency strips flow characters, no exception
// - Bit 2 requests when transmit FIFO empty
// - Enabling bit 2 on empty FIFO requests immediately
// - Host toggles bit 2 to regulate transmit
// - Bit 1 requests when all transmit stages empty
// - Bit 0 raises exception after idle time-out
// - Host sets one command bit per write
// - Bits 7..4 select reset, option, send, control
// - Qualifier bits interpreted per selected command
// - Command register clears when command completes
// - Completion latency is variable and unbounded
// - Host waits for zero before next command
// - Host waits after loopback change before sending
// - Channel access register selects per-channel copy
// - Reset qualifier selects channel or global reset
`timescale 1ns/1ps
`default_nettype none
module chan_dev #(
  parameter int unsigned NCH         = 8,
  parameter int unsigned IDLE_CYCLES = chan_pkg::RX_IDLE_CYCLES
) (
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  chan_if.dev                           bus,
  input  wire logic [NCH-1:0]           dsr_chg,
  input  wire logic [NCH-1:0]           cd_chg,
  input  wire logic [NCH-1:0]           cts_chg,
  input  wire logic [NCH-1:0]           rx_valid,
  input  wire logic [NCH-1:0]           rx_err,
  input  wire logic [NCH-1:0][7:0]      rx_char,
  input  wire logic [3:0][7:0]          spec_char,
  input  wire logic [NCH-1:0]           flow_transparent,
  input  wire logic [NCH-1:0]           tx_fifo_empty,
  input  wire logic [NCH-1:0]           tx_line_idle,
  input  wire logic                     cmd_done,
  input  wire logic [$clog2(NCH)-1:0]   cmd_done_chan,
  output logic                          cmd_valid,
  output logic [$clog2(NCH)-1:0]        cmd_chan,
  output chan_pkg::cmd_kind_e           cmd_kind,
  output logic [3:0]                    cmd_qual,
  output logic [NCH-1:0]                chan_flush,
  output logic                          global_reset,
  output logic [NCH-1:0]                rx_keep
);

  localparam int unsigned CW = $clog2(NCH);
  localparam int unsigned TW = $clog2(IDLE_CYCLES + 1);
  localparam logic [TW-1:0] TMR_LAST = TW'(IDLE_CYCLES - 1);

  typedef struct packed {
    logic [CW-1:0]           chan;
    logic [NCH-1:0][7:0]     en;
    logic [NCH-1:0][7:0]     cmd;
    logic [NCH-1:0]          modem_p;
    logic [NCH-1:0]          rx_p;
    logic [NCH-1:0]          exc_p;
    logic [NCH-1:0]          txr;
    logic [NCH-1:0]          txe;
    logic [NCH-1:0]          tmr_on;
    logic [NCH-1:0][TW-1:0]  tmr;
    logic [7:0]              rdata;
    logic                    rvalid;
    logic                    cmd_valid;
    logic [CW-1:0]           cmd_chan;
    chan_pkg::cmd_kind_e     kind;
    logic [3:0]              qual;
    logic [NCH-1:0]          flush;
    logic                    greset;
    logic [NCH-1:0]          keep;
  } dev_state_s;

  dev_state_s q;
  dev_state_s d;

  // Per-channel requests, timers and register port
  always_comb begin
    logic       sc;
    logic       strip;
    logic       fire;
    logic [7:0] w;
    sc    = 1'b0;
    strip = 1'b0;
    fire  = 1'b0;
    w     = bus.wdata;
    d           = q;
    d.rvalid    = 1'b0;
    d.cmd_valid = 1'b0;
    d.flush     = '0;
    d.greset    = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      sc = 1'b0;
      for (int k = 0; k < 4; k++) begin
        if (rx_char[i] == spec_char[k]) sc = 1'b1;
      end
      strip = flow_transparent[i] &&
              (rx_char[i] == spec_char[0] || rx_char[i] == spec_char[1]);
      d.keep[i] = rx_valid[i] && !strip;
      // Idle timer starts at each completed transfer, stops on new data
      fire = 1'b0;
      if (rx_valid[i]) begin
        d.tmr_on[i] = 1'b0;
      end else if (bus.ack_rx[i]) begin
        d.tmr_on[i] = 1'b1;
        d.tmr[i]    = '0;
      end else if (q.tmr_on[i]) begin
        if (q.tmr[i] == TMR_LAST) begin
          d.tmr_on[i] = 1'b0;
          fire        = q.en[i][chan_pkg::SRE_IDLE_TO];
        end else begin
          d.tmr[i] = q.tmr[i] + TW'(1);
        end
      end
      // Sticky requests: host ack clears, a new event wins
      if (bus.ack_modem[i]) d.modem_p[i] = 1'b0;
      if ((dsr_chg[i] && q.en[i][chan_pkg::SRE_DSR]) ||
          (cd_chg[i]  && q.en[i][chan_pkg::SRE_CD])  ||
          (cts_chg[i] && q.en[i][chan_pkg::SRE_CTS]))
        d.modem_p[i] = 1'b1;
      if (bus.ack_rx[i]) d.rx_p[i] = 1'b0;
      if (rx_valid[i] && !rx_err[i] && !strip && q.en[i][chan_pkg::SRE_RXD])
        d.rx_p[i] = 1'b1;
      if (bus.ack_exc[i]) d.exc_p[i] = 1'b0;
      if ((rx_valid[i] && rx_err[i] && q.en[i][chan_pkg::SRE_RXD]) ||
          (rx_valid[i] && sc && !strip && q.en[i][chan_pkg::SRE_SPEC]) ||
          fire)
        d.exc_p[i] = 1'b1;
      // Level requests follow enable at once, so enabling on empty requests
      d.txr[i] = q.en[i][chan_pkg::SRE_TXR] && tx_fifo_empty[i];
      d.txe[i] = q.en[i][chan_pkg::SRE_TXE] && tx_fifo_empty[i] && tx_line_idle[i];
    end
    // Register writes through the channel access pointer
    if (bus.wr) begin
      unique case (bus.addr)
        chan_pkg::OFS_CHAN: d.chan = w[CW-1:0];
        chan_pkg::OFS_SRE:  d.en[q.chan] = w;
        chan_pkg::OFS_CMD: begin
          if (q.cmd[q.chan] == chan_pkg::CMD_IDLE && w[7:4] != 4'h0) begin
            d.cmd[q.chan] = w;
            d.cmd_valid   = 1'b1;
            d.cmd_chan    = q.chan;
            d.qual        = w[3:0];
            if (w[chan_pkg::CMD_RESET_BIT]) begin
              d.kind = chan_pkg::CMD_RST;
              if (w[chan_pkg::RESET_TYPE_BIT]) d.greset = 1'b1;
              else d.flush[q.chan] = 1'b1;
            end else if (w[chan_pkg::CMD_OPT_BIT]) begin
              d.kind = chan_pkg::CMD_OPTION;
            end else if (w[chan_pkg::CMD_SEND_BIT]) begin
              d.kind = chan_pkg::CMD_SEND;
            end else begin
              d.kind = chan_pkg::CMD_CONTROL;
            end
          end
        end
        default: ;
      endcase
    end
    // Register reads, answered one cycle later
    if (bus.rd) begin
      d.rvalid = 1'b1;
      unique case (bus.addr)
        chan_pkg::OFS_CHAN: d.rdata = 8'(q.chan);
        chan_pkg::OFS_SRE:  d.rdata = q.en[q.chan];
        chan_pkg::OFS_CMD:  d.rdata = q.cmd[q.chan];
        default:            d.rdata = 8'h00;
      endcase
    end
    // Completion from the internal processor, at any latency
    if (cmd_done) begin
      d.cmd[cmd_done_chan] = chan_pkg::CMD_IDLE;
      if (q.cmd[cmd_done_chan][chan_pkg::CMD_RESET_BIT] &&
          q.cmd[cmd_done_chan][chan_pkg::RESET_TYPE_BIT]) begin
        d.en      = '0;
        d.cmd     = '0;
        d.chan    = '0;
        d.modem_p = '0;
        d.rx_p    = '0;
        d.exc_p   = '0;
        d.tmr_on  = '0;
      end
    end
  end

  // State register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bus.rdata      = q.rdata;
  assign bus.rvalid     = q.rvalid;
  assign bus.modem_req  = q.modem_p;
  assign bus.rx_req     = q.rx_p;
  assign bus.rx_exc_req = q.exc_p;
  assign bus.tx_req     = q.txr;
  assign bus.txe_req    = q.txe;
  assign cmd_valid      = q.cmd_valid;
  assign cmd_chan       = q.cmd_chan;
  assign cmd_kind       = q.kind;
  assign cmd_qual       = q.qual;
  assign chan_flush     = q.flush;
  assign global_reset   = q.greset;
  assign rx_keep        = q.keep;

endmodule : chan_dev
`default_nettype wire

// ==== verilog/chan_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module chan_host #(
  parameter int unsigned NCH = 8
) (
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  chan_if.host                        bus,
  input  wire logic                   req_valid,
  input  wire chan_pkg::host_op_e     req_op,
  input  wire logic [$clog2(NCH)-1:0] req_chan,
  input  wire logic [7:0]             req_addr,
  input  wire logic [7:0]             req_wdata,
  output logic                        req_ready,
  output logic                        resp_valid,
  output logic [7:0]                  resp_rdata,
  input  wire logic [NCH-1:0]         ack_modem,
  input  wire logic [NCH-1:0]         ack_rx,
  input  wire logic [NCH-1:0]         ack_exc,
  output logic [NCH-1:0]              modem_req,
  output logic [NCH-1:0]              rx_req,
  output logic [NCH-1:0]              rx_exc_req,
  output logic [NCH-1:0]              tx_req,
  output logic [NCH-1:0]              txe_req
);

  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_ACC   = 2'b01,
    S_RWAIT = 2'b10,
    S_POLL  = 2'b11
  } host_st_e;

  typedef struct packed {
    host_st_e            st;
    chan_pkg::host_op_e  op;
    logic [7:0]          a;
    logic [7:0]          wd;
    logic [7:0]          addr;
    logic [7:0]          wdata;
    logic                wr;
    logic                rd;
    logic                ready;
    logic                rv;
    logic [7:0]          rdat;
    logic [NCH-1:0]      am;
    logic [NCH-1:0]      ar;
    logic [NCH-1:0]      ae;
    logic [NCH-1:0]      mq;
    logic [NCH-1:0]      rq;
    logic [NCH-1:0]      eq;
    logic [NCH-1:0]      tq;
    logic [NCH-1:0]      teq;
  } host_state_s;

  host_state_s q;
  host_state_s d;

  // Access sequencer: select channel, access, poll commands to zero
  always_comb begin
    d     = q;
    d.wr  = 1'b0;
    d.rd  = 1'b0;
    d.rv  = 1'b0;
    d.am  = ack_modem;
    d.ar  = ack_rx;
    d.ae  = ack_exc;
    d.mq  = bus.modem_req;
    d.rq  = bus.rx_req;
    d.eq  = bus.rx_exc_req;
    d.tq  = bus.tx_req;
    d.teq = bus.txe_req;
    unique case (q.st)
      S_IDLE: begin
        if (req_valid) begin
          d.op    = req_op;
          d.a     = req_addr;
          d.wd    = req_wdata;
          d.wr    = 1'b1;
          d.addr  = chan_pkg::OFS_CHAN;
          d.wdata = 8'(req_chan);
          d.st    = S_ACC;
        end
      end
      S_ACC: begin
        unique case (q.op)
          chan_pkg::OP_WRITE: begin
            d.wr    = 1'b1;
            d.addr  = q.a;
            d.wdata = q.wd;
            d.rv    = 1'b1;
            d.rdat  = 8'h00;
            d.st    = S_IDLE;
          end
          chan_pkg::OP_CMD: begin
            d.wr    = 1'b1;
            d.addr  = chan_pkg::OFS_CMD;
            d.wdata = q.wd;
            d.st    = S_POLL;
          end
          default: begin
            d.rd   = 1'b1;
            d.addr = q.a;
            d.st   = S_RWAIT;
          end
        endcase
      end
      S_POLL: begin
        d.rd   = 1'b1;
        d.addr = chan_pkg::OFS_CMD;
        d.st   = S_RWAIT;
      end
      S_RWAIT: begin
        if (bus.rvalid) begin
          if (q.op == chan_pkg::OP_CMD && bus.rdata != chan_pkg::CMD_IDLE) begin
            d.st = S_POLL;
          end else begin
            d.rv   = 1'b1;
            d.rdat = bus.rdata;
            d.st   = S_IDLE;
          end
        end
      end
    endcase
    d.ready = (d.st == S_IDLE);
  end

  // State register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bus.addr      = q.addr;
  assign bus.wdata     = q.wdata;
  assign bus.wr        = q.wr;
  assign bus.rd        = q.rd;
  assign bus.ack_modem = q.am;
  assign bus.ack_rx    = q.ar;
  assign bus.ack_exc   = q.ae;
  assign req_ready     = q.ready;
  assign resp_valid    = q.rv;
  assign resp_rdata    = q.rdat;
  assign modem_req     = q.mq;
  assign rx_req        = q.rq;
  assign rx_exc_req    = q.eq;
  assign tx_req        = q.tq;
  assign txe_req       = q.teq;

endmodule : chan_host
`default_nettype wire

// ==== dv/chan_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module chan_assertions #(
  parameter int unsigned NCH = 8
) (
  input wire logic           clk,
  input wire logic           sys_rst,
  input wire logic [7:0]     addr,
  input wire logic [7:0]     wdata,
  input wire logic           wr,
  input wire logic           rd,
  input wire logic [7:0]     rdata,
  input wire logic           rvalid,
  input wire logic [NCH-1:0] modem_req,
  input wire logic [NCH-1:0] rx_req,
  input wire logic [NCH-1:0] rx_exc_req,
  input wire logic [NCH-1:0] tx_req,
  input wire logic [NCH-1:0] txe_req,
  input wire logic [NCH-1:0] ack_modem,
  input wire logic [NCH-1:0] ack_rx,
  input wire logic [NCH-1:0] ack_exc
);
  logic [$clog2(NCH)-1:0] ptr_q;
  logic [7:0]             sre_q [NCH];
  logic [7:0]             cmd_q [NCH];
  logic                   gr_q;
  logic                   rdcmd_q;

  // Shadow of the per-channel registers; global reset makes it stale
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ptr_q <= '0;
      gr_q <= 1'b0;
      rdcmd_q <= 1'b0;
      sre_q <= '{default: 8'h00};
      cmd_q <= '{default: 8'h00};
    end else begin
      rdcmd_q <= rd && addr == chan_pkg::OFS_CMD;
      if (wr && addr == chan_pkg::OFS_CHAN) ptr_q <= wdata[$clog2(NCH)-1:0];
      if (wr && addr == chan_pkg::OFS_SRE) sre_q[ptr_q] <= wdata;
      if (wr && addr == chan_pkg::OFS_CMD && cmd_q[ptr_q] == 8'h00 && wdata[7:4] != 4'h0) begin
        cmd_q[ptr_q] <= wdata;
        gr_q <= gr_q | (wdata[7] & wdata[0]);
      end
      if (rdcmd_q && rdata == 8'h00) cmd_q[ptr_q] <= 8'h00;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  property p_read_answer;
    rd |=> rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read strobe without answer");
  property p_rvalid_cause;
    rvalid |-> $past(rd);
  endproperty
  a_rvalid_cause: assert property (p_rvalid_cause)
    else $error("answer without read strobe");
  property p_ptr_read;
    rd && addr == chan_pkg::OFS_CHAN && !gr_q |=> rdata == 8'(ptr_q);
  endproperty
  a_ptr_read: assert property (p_ptr_read)
    else $error("channel pointer reads wrong");
  property p_sre_read;
    rd && addr == chan_pkg::OFS_SRE && !gr_q |=> rdata == sre_q[ptr_q];
  endproperty
  a_sre_read: assert property (p_sre_read)
    else $error("enable register reads wrong");
  property p_cmd_read;
    rd && addr == chan_pkg::OFS_CMD |=> rdata == cmd_q[ptr_q] || rdata == 8'h00;
  endproperty
  a_cmd_read: assert property (p_cmd_read)
    else $error("command register reads wrong");
  property p_modem_sticky;
    !gr_q |-> ($past(modem_req) & ~modem_req & ~$past(ack_modem)) == '0;
  endproperty
  a_modem_sticky: assert property (p_modem_sticky)
    else $error("modem request dropped without ack");
  property p_rx_sticky;
    !gr_q |-> (($past(rx_req) & ~rx_req & ~$past(ack_rx))
      | ($past(rx_exc_req) & ~rx_exc_req & ~$past(ack_exc))) == '0;
  endproperty
  a_rx_sticky: assert property (p_rx_sticky)
    else $error("receive request dropped without ack");
  property p_reset_clear;
    $past(sys_rst) |-> (modem_req | rx_req | rx_exc_req | tx_req | txe_req) == '0 && !rvalid;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("requests active after reset");

  // Main scenarios reached
  c_cmd: cover property (wr && addr == chan_pkg::OFS_CMD && wdata[7:4] != 4'h0);
  c_modem: cover property (|modem_req);
  c_exc: cover property (|rx_exc_req);
endmodule : chan_assertions
`default_nettype wire

// ==== dv/channel_request_enable_and_command_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module channel_request_enable_and_command_tb;
  logic                clk = 1'b0;
  logic                sys_rst, req_valid, req_ready, resp_valid;
  logic                cmd_done, cmd_valid, global_reset, flush_s, gr_s;
  chan_pkg::host_op_e  req_op;
  chan_pkg::cmd_kind_e cmd_kind, kind_s;
  logic [2:0]          req_chan, cmd_done_chan, cmd_chan, pend_ch, c;
  logic [3:0]          cmd_qual, qual_s;
  logic [7:0]          req_addr, req_wdata, resp_rdata, r, d;
  logic [7:0]          ack_modem, ack_rx, ack_exc, modem_req, rx_req, rx_exc_req, tx_req;
  logic [7:0]          txe_req, dsr_chg, cd_chg, cts_chg, rx_valid, rx_err, flow_transparent;
  logic [7:0]          tx_fifo_empty, tx_line_idle, chan_flush, rx_keep, en [8];
  logic [7:0][7:0]     rx_char;
  logic [3:0][7:0]     spec_char;
  int                  bad_count, n_compared, lat, lat_base, i, n;

  chan_if #(.NCH(8)) bus_if ();
  chan_host #(.NCH(8)) chan_host_inst (
    .clk, .sys_rst, .bus(bus_if), .req_valid, .req_op, .req_chan, .req_addr, .req_wdata,
    .req_ready, .resp_valid, .resp_rdata, .ack_modem, .ack_rx, .ack_exc, .modem_req,
    .rx_req, .rx_exc_req, .tx_req, .txe_req
  );
  chan_dev #(.NCH(8), .IDLE_CYCLES(4)) chan_dev_inst (
    .clk, .sys_rst, .bus(bus_if), .dsr_chg, .cd_chg, .cts_chg, .rx_valid, .rx_err, .rx_char,
    .spec_char, .flow_transparent, .tx_fifo_empty, .tx_line_idle, .cmd_done, .cmd_done_chan,
    .cmd_valid, .cmd_chan, .cmd_kind, .cmd_qual, .chan_flush, .global_reset, .rx_keep
  );
  chan_assertions #(.NCH(8)) chan_assertions_inst (
    .clk, .sys_rst, .addr(bus_if.addr), .wdata(bus_if.wdata), .wr(bus_if.wr), .rd(bus_if.rd),
    .rdata(bus_if.rdata), .rvalid(bus_if.rvalid), .modem_req(bus_if.modem_req),
    .rx_req(bus_if.rx_req), .rx_exc_req(bus_if.rx_exc_req), .tx_req(bus_if.tx_req),
    .txe_req(bus_if.txe_req), .ack_modem(bus_if.ack_modem), .ack_rx(bus_if.ack_rx),
    .ack_exc(bus_if.ack_exc)
  );

  // Clock, 8 ns period
  always #4 clk = ~clk;

  // Stand-in processor: captures each issued command, completes it after a random delay
  always @(negedge clk) begin
    cmd_done <= 1'b0;
    if (cmd_valid === 1'b1) begin
      lat <= lat_base + int'($urandom % 8);
      pend_ch <= cmd_chan;
      kind_s <= cmd_kind;
      qual_s <= cmd_qual;
      flush_s <= chan_flush[cmd_chan];
      gr_s <= global_reset;
    end else if (lat > 0) begin
      lat <= lat - 1;
      if (lat == 1) begin
        cmd_done <= 1'b1;
        cmd_done_chan <= pend_ch;
      end
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  function automatic chan_pkg::cmd_kind_e exp_kind(input logic [7:0] v);
    if (v[7]) return chan_pkg::CMD_RST;
    if (v[6]) return chan_pkg::CMD_OPTION;
    if (v[5]) return chan_pkg::CMD_SEND;
    if (v[4]) return chan_pkg::CMD_CONTROL;
    return chan_pkg::CMD_NONE;
  endfunction : exp_kind

  // One host request, driven for one cycle once ready, then bounded wait for its response
  task automatic host_op(input chan_pkg::host_op_e op, input logic [2:0] ch,
                         input logic [7:0] a, input logic [7:0] v, output logic [7:0] rv);
    int k;
    k = 0;
    while (req_ready !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    req_valid = 1'b1;
    req_op = op;
    req_chan = ch;
    req_addr = a;
    req_wdata = v;
    @(negedge clk);
    req_valid = 1'b0;
    k = 0;
    while (resp_valid !== 1'b1 && k < 2000) begin
      @(negedge clk);
      k++;
    end
    chk("resp_valid", 8'h01, 8'(resp_valid));
    rv = resp_rdata;
  endtask : host_op

  // One request cause on one channel with a given enable value, then ack and idle time-out
  task automatic ev(input int k, input logic [2:0] ch, input logic [7:0] e);
    logic [7:0] rv;
    tx_fifo_empty[ch] = 1'($urandom);
    tx_line_idle[ch] = 1'($urandom);
    host_op(chan_pkg::OP_WRITE, ch, chan_pkg::OFS_SRE, e, rv);
    // Response comes with the bus write, so let the enable land first
    @(negedge clk);
    dsr_chg[ch] = (k == 0);
    cd_chg[ch] = (k == 1);
    cts_chg[ch] = (k == 2);
    rx_valid[ch] = (k > 2);
    rx_err[ch] = (k == 4);
    rx_char[ch] = (k == 5) ? spec_char[2] : (k == 6) ? spec_char[0] : 8'h41;
    flow_transparent[ch] = (k == 6);
    @(negedge clk);
    {dsr_chg, cd_chg, cts_chg, rx_valid} = '0;
    chk("rx_keep", 8'(k > 2 && k != 6), 8'(rx_keep[ch]));
    repeat (3) @(negedge clk);
    chk("modem", 8'(k < 3 && e[7-k]), 8'(modem_req[ch]));
    chk("rx", 8'((k == 3 || k == 5) && e[4]), 8'(rx_req[ch]));
    chk("exc", 8'((k == 4 && e[4]) || (k == 5 && e[3])), 8'(rx_exc_req[ch]));
    chk("tx", 8'(e[2] && tx_fifo_empty[ch]), 8'(tx_req[ch]));
    chk("txe", 8'(e[1] && tx_fifo_empty[ch] && tx_line_idle[ch]), 8'(txe_req[ch]));
    {ack_modem[ch], ack_rx[ch], ack_exc[ch]} = 3'h7;
    @(negedge clk);
    {ack_modem, ack_rx, ack_exc} = '0;
    repeat (10) @(negedge clk);
    chk("exc_idle", 8'(e[0]), 8'(rx_exc_req[ch]));
    chk("acked", 8'h00, 8'({modem_req[ch], rx_req[ch]}));
    ack_exc[ch] = 1'b1;
    @(negedge clk);
    ack_exc = '0;
    repeat (3) @(negedge clk);
  endtask : ev

  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  // Cuts a hung run short
  initial begin
    #(8 * 40000);
    bad_count++;
    print_verdict;
  end

  // Main sequence
  initial begin
    void'($urandom(20157));
    {req_valid, req_chan, req_addr, req_wdata} = '0;
    sys_rst = 1'b1;
    req_op = chan_pkg::OP_READ;
    {ack_modem, ack_rx, ack_exc, dsr_chg, cd_chg, cts_chg, rx_valid, rx_err} = '0;
    {flow_transparent, tx_fifo_empty, tx_line_idle, rx_char} = '0;
    spec_char = {8'h13, 8'h11, 8'h2A, 8'h3C};
    lat_base = 3;
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    c = 3'($urandom);
    host_op(chan_pkg::OP_READ, c, chan_pkg::OFS_SRE, 8'h00, r);
    chk("sre_reset", 8'h00, r);
    host_op(chan_pkg::OP_READ, c, chan_pkg::OFS_CMD, 8'h00, r);
    chk("cmd_reset", 8'h00, r);
    for (i = 0; i < 8; i++) begin
      en[i] = 8'($urandom);
      host_op(chan_pkg::OP_WRITE, 3'(i), chan_pkg::OFS_SRE, en[i], r);
    end
    for (i = 0; i < 8; i++) begin
      host_op(chan_pkg::OP_READ, 3'(i), chan_pkg::OFS_SRE, 8'h00, r);
      chk("sre", en[i], r);
    end
    host_op(chan_pkg::OP_READ, 3'h3, chan_pkg::OFS_CHAN, 8'h00, r);
    chk("pointer", 8'h03, r);
    host_op(chan_pkg::OP_READ, 3'h0, 8'h03, 8'h00, r);
    chk("unmapped", 8'h00, r);
    for (i = 0; i < 7; i++) begin
      ev(i, 3'h7, 8'hFF);
      ev(i, 3'h0, 8'h00);
    end
    repeat (60) ev(int'($urandom % 7), 3'($urandom), 8'($urandom));
    for (i = 0; i < 4; i++) begin
      d = (8'h80 >> i) | ((i == 0) ? 8'h00 : 8'($urandom % 16));
      c = 3'($urandom);
      host_op(chan_pkg::OP_CMD, c, chan_pkg::OFS_CMD, d, r);
      chk("cmd_final", 8'h00, r);
      chk("kind", 8'(exp_kind(d)), 8'(kind_s));
      chk("qual", 8'(d[3:0]), 8'(qual_s));
      chk("flush", 8'(i == 0), 8'(flush_s));
      chk("cmd_chan", 8'(c), 8'(pend_ch));
    end
    lat_base = 60;
    c = 3'($urandom);
    d = {4'h1, 4'($urandom)};
    host_op(chan_pkg::OP_WRITE, c, chan_pkg::OFS_CMD, d, r);
    host_op(chan_pkg::OP_READ, c, chan_pkg::OFS_CMD, 8'h00, r);
    chk("pending", d, r);
    host_op(chan_pkg::OP_WRITE, c, chan_pkg::OFS_CMD, 8'h40, r);
    host_op(chan_pkg::OP_READ, c, chan_pkg::OFS_CMD, 8'h00, r);
    chk("busy_write", d, r);
    n = 0;
    do begin
      host_op(chan_pkg::OP_READ, c, chan_pkg::OFS_CMD, 8'h00, r);
      n++;
    end while (r !== 8'h00 && n < 40);
    chk("cmd_cleared", 8'h00, r);
    host_op(chan_pkg::OP_WRITE, c, chan_pkg::OFS_CMD, 8'h05, r);
    host_op(chan_pkg::OP_READ, c, chan_pkg::OFS_CMD, 8'h00, r);
    chk("no_cmd_bit", 8'h00, r);
    lat_base = 3;
    host_op(chan_pkg::OP_CMD, 3'h0, chan_pkg::OFS_CMD, 8'h81, r);
    chk("global", 8'h01, 8'(gr_s));
    host_op(chan_pkg::OP_READ, 3'h5, chan_pkg::OFS_SRE, 8'h00, r);
    chk("sre_global", 8'h00, r);
    print_verdict;
  end
endmodule : channel_request_enable_and_command_tb
`default_nettype wire
